// File: shared/atri_pkg.sv
// Shared constants and bus carriers for the asynchronous timer register block.
// Assumes a 32-bit AXI4-Lite master and one 50 MHz system clock.
package atri_pkg;
  localparam int ATRI_ADDR_W = 12;
  localparam int ATRI_PRESC_W = 10;

  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid;
    logic [ATRI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ATRI_ADDR_W-1:0] araddr;
    logic rready;
  } atri_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } atri_axi_rsp_s;

  localparam logic [1:0] ATRI_RESP_OKAY = 2'h0;
  localparam logic [1:0] ATRI_RESP_SLVERR = 2'h2;

  // Register indices, byte address is four times the index
  localparam logic [7:0] ATRI_IDX_SYNC_PRESC = 8'h43;
  localparam logic [7:0] ATRI_IDX_ASYNC_STAT = 8'hb6;
  localparam logic [7:0] ATRI_IDX_CTRL_A = 8'hb0;
  localparam logic [7:0] ATRI_IDX_CTRL_B = 8'hb1;
  localparam logic [7:0] ATRI_IDX_COUNT = 8'hb2;
  localparam logic [7:0] ATRI_IDX_CMP_A = 8'hb3;
  localparam logic [7:0] ATRI_IDX_CMP_B = 8'hb4;
  localparam logic [7:0] ATRI_IDX_IRQ_MASK = 8'h70;
  localparam logic [7:0] ATRI_IDX_IRQ_FLAGS = 8'h37;

  // Field positions
  localparam int ATRI_BIT_EXT_CLOCK_IN_ENABLE = 6;
  localparam int ATRI_BIT_ASYNC = 5;
  localparam int ATRI_BIT_TSM = 7;
  localparam int ATRI_BIT_ASYNC_PRESCALER_RESET = 1;
  localparam int ATRI_BIT_SHARED_PRESCALER_RESET = 0;
  localparam int ATRI_BUSY_CNT = 4;
  localparam int ATRI_BUSY_CMPA = 3;
  localparam int ATRI_BUSY_CMPB = 2;
  localparam int ATRI_BUSY_CTLA = 1;
  localparam int ATRI_BUSY_CTLB = 0;
  localparam int ATRI_FLAG_CMPB = 2;
  localparam int ATRI_FLAG_CMPA = 1;
  localparam int ATRI_FLAG_OVF = 0;

  // Reset values and read masks
  localparam logic [7:0] ATRI_RST_BYTE = 8'h00;
  localparam logic [7:0] ATRI_CTLA_RD_MASK = 8'hf3;
  localparam logic [7:0] ATRI_CTLB_RD_MASK = 8'h0f;
  localparam logic [7:0] ATRI_IRQ_BITS = 8'h07;
  localparam logic [7:0] ATRI_BOTTOM = 8'h00;
  localparam logic [7:0] ATRI_MAX = 8'hff;

  // Prescaler tap masks for divide by 8, 32, 64, 128, 256, 1024
  localparam logic [9:0] ATRI_DIV8 = 10'h007;
  localparam logic [9:0] ATRI_DIV32 = 10'h01f;
  localparam logic [9:0] ATRI_DIV64 = 10'h03f;
  localparam logic [9:0] ATRI_DIV128 = 10'h07f;
  localparam logic [9:0] ATRI_DIV256 = 10'h0ff;
  localparam logic [9:0] ATRI_DIV1024 = 10'h3ff;

  typedef enum logic [1:0] {ATRI_NORMAL, ATRI_PHASE, ATRI_CTC, ATRI_FAST} atri_mode_e;
endpackage : atri_pkg

// File: hdl/atri_sync2.sv
// Two-flop level synchroniser.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module atri_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : atri_sync2
`default_nettype wire

// File: hdl/atri_timer.sv
// Asynchronous 8-bit timer with temporary storage, busy flags and prescaler control.
// Assumes an AXI4-Lite master on clk; oscillator pin sampled through a synchroniser.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Count write blocks next tick's compare match
// - Two 8-bit compares raise match, drive pins
// - External buffer when ext and async; crystal when async without ext
// - Async select picks oscillator, else system clock
// - Async writes set busy until target loaded
// - Count reads live; compares and controls read temporary storage
// - Request needs mask, global enable and flag
// - Compare B flag set on match, cleared
// - Compare A flag set on match, cleared
// - Overflow flag set on overflow, cleared
// - Phase PWM overflow flag at direction reversal zero
// - Sync mode holds reset bits; clearing releases
// - Async prescaler reset self-clears per mode
// - Shared prescaler reset clears unless sync mode
module atri_timer
  import atri_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire atri_axi_req_s axi_req,
  output atri_axi_rsp_s axi_rsp,
  // Oscillator pin and its controls
  input wire logic timer_osc_in_pin,
  output logic ext_clock_in_enable,
  output logic osc_run,
  // Processor side interrupt
  input wire logic cpu_global_irq_en,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  // Waveform and shared prescaler
  output logic wave_out_a,
  output logic wave_out_b,
  output logic shared_prescaler_reset
);
  logic aw_full_r, w_full_r, bvalid_r, rvalid_r, berr_r, rerr_r;
  logic [ATRI_ADDR_W-1:0] waddr_r;
  logic [7:0] wdata_r, rdata_r;
  logic wstrb0_r;
  logic [7:0] cnt_r, cnt_t, ocr_r [2], ocr_t [2], ctla_r, ctla_t, ctlb_r, ctlb_t;
  logic [4:0] busy_r;
  logic ext_clock_in_enable_r, as_r, tsm_r, async_prescaler_reset_r, shared_prescaler_reset_r, up_r, block_r;
  logic [2:0] mask_r, flags_r;
  logic [ATRI_PRESC_W-1:0] presc_r;
  logic osc_s, osc_prev_r;
  logic [1:0] wave_r, force_r;

  // Bus slave decode
  wire aw_fire = axi_req.awvalid & ~aw_full_r;
  wire w_fire = axi_req.wvalid & ~w_full_r;
  wire wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  wire [7:0] wr_idx = waddr_r[9:2];
  wire [7:0] rd_idx = axi_req.araddr[9:2];
  wire wen = wr_fire & wstrb0_r;
  wire wr_hit = (wr_idx == ATRI_IDX_SYNC_PRESC) | (wr_idx == ATRI_IDX_ASYNC_STAT) |
                (wr_idx == ATRI_IDX_CTRL_A) | (wr_idx == ATRI_IDX_CTRL_B) |
                (wr_idx == ATRI_IDX_COUNT) | (wr_idx == ATRI_IDX_CMP_A) |
                (wr_idx == ATRI_IDX_CMP_B) | (wr_idx == ATRI_IDX_IRQ_MASK) |
                (wr_idx == ATRI_IDX_IRQ_FLAGS);
  wire wr_cnt = wen & (wr_idx == ATRI_IDX_COUNT);
  wire wr_cmpa = wen & (wr_idx == ATRI_IDX_CMP_A);
  wire wr_cmpb = wen & (wr_idx == ATRI_IDX_CMP_B);
  wire wr_ctla = wen & (wr_idx == ATRI_IDX_CTRL_A);
  wire wr_ctlb = wen & (wr_idx == ATRI_IDX_CTRL_B);
  wire wr_stat = wen & (wr_idx == ATRI_IDX_ASYNC_STAT);
  wire wr_gtc = wen & (wr_idx == ATRI_IDX_SYNC_PRESC);
  wire wr_mask = wen & (wr_idx == ATRI_IDX_IRQ_MASK);
  wire wr_flags = wen & (wr_idx == ATRI_IDX_IRQ_FLAGS);
  wire ar_fire = axi_req.arvalid & ~rvalid_r;
  wire [4:0] wr_vec = {wr_cnt, wr_cmpa, wr_cmpb, wr_ctla, wr_ctlb};

  // Read mux: compares and controls come from temporary storage
  logic rd_hit;
  logic [7:0] rd_val;
  always_comb begin
    rd_hit = 1'b1;
    case (rd_idx)
      ATRI_IDX_COUNT: rd_val = cnt_r;
      ATRI_IDX_CMP_A: rd_val = ocr_t[0];
      ATRI_IDX_CMP_B: rd_val = ocr_t[1];
      ATRI_IDX_CTRL_A: rd_val = ctla_t & ATRI_CTLA_RD_MASK;
      ATRI_IDX_CTRL_B: rd_val = ctlb_t & ATRI_CTLB_RD_MASK;
      ATRI_IDX_ASYNC_STAT: rd_val = {1'b0, ext_clock_in_enable_r, as_r, busy_r};
      ATRI_IDX_SYNC_PRESC: rd_val = {tsm_r, 5'h00, async_prescaler_reset_r, shared_prescaler_reset_r};
      ATRI_IDX_IRQ_MASK: rd_val = {5'h00, mask_r};
      ATRI_IDX_IRQ_FLAGS: rd_val = {5'h00, flags_r};
      default: begin
        rd_val = ATRI_RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign axi_rsp = '{awready: ~aw_full_r, wready: ~w_full_r, bvalid: bvalid_r,
                     bresp: berr_r ? ATRI_RESP_SLVERR : ATRI_RESP_OKAY,
                     arready: ~rvalid_r, rvalid: rvalid_r, rdata: {24'h000000, rdata_r},
                     rresp: rerr_r ? ATRI_RESP_SLVERR : ATRI_RESP_OKAY};

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      berr_r <= 1'b0;
      rvalid_r <= 1'b0;
      rerr_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= ATRI_RST_BYTE;
      wstrb0_r <= 1'b0;
      rdata_r <= ATRI_RST_BYTE;
    end else begin
      if (aw_fire) aw_full_r <= 1'b1;
      else if (wr_fire) aw_full_r <= 1'b0;
      if (w_fire) w_full_r <= 1'b1;
      else if (wr_fire) w_full_r <= 1'b0;
      if (aw_fire) waddr_r <= axi_req.awaddr;
      if (w_fire) wdata_r <= axi_req.wdata[7:0];
      if (w_fire) wstrb0_r <= axi_req.wstrb[0];
      if (wr_fire) bvalid_r <= 1'b1;
      else if (axi_req.bready) bvalid_r <= 1'b0;
      if (wr_fire) berr_r <= ~wr_hit;
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rerr_r <= ~rd_hit;
      end else if (axi_req.rready) rvalid_r <= 1'b0;
    end
  end

  // Oscillator edge; first synchroniser flop is private to atri_sync2
  atri_sync2 #(.WIDTH(1)) u_osc_sync (.clk(clk), .srst(srst), .d(timer_osc_in_pin), .q(osc_s));
  wire osc_edge = osc_s & ~osc_prev_r;
  wire base_en = as_r ? osc_edge : 1'b1;
  wire load_en = as_r & osc_edge;
  assign ext_clock_in_enable = ext_clock_in_enable_r & as_r;
  assign osc_run = as_r & ~ext_clock_in_enable_r;

  // Prescaler and clock select
  wire presc_hold = async_prescaler_reset_r;
  logic tick;
  always_comb begin
    case (ctlb_r[2:0])
      3'h1: tick = base_en;
      3'h2: tick = base_en & ((presc_r & ATRI_DIV8) == ATRI_DIV8);
      3'h3: tick = base_en & ((presc_r & ATRI_DIV32) == ATRI_DIV32);
      3'h4: tick = base_en & ((presc_r & ATRI_DIV64) == ATRI_DIV64);
      3'h5: tick = base_en & ((presc_r & ATRI_DIV128) == ATRI_DIV128);
      3'h6: tick = base_en & ((presc_r & ATRI_DIV256) == ATRI_DIV256);
      3'h7: tick = base_en & ((presc_r & ATRI_DIV1024) == ATRI_DIV1024);
      default: tick = 1'b0;
    endcase
    if (presc_hold) tick = 1'b0;
  end
  assign shared_prescaler_reset = shared_prescaler_reset_r;

  // Counting sequence
  atri_mode_e mode;
  assign mode = atri_mode_e'(ctla_r[1:0]);
  wire [7:0] top = ctlb_r[3] ? ocr_r[0] : ATRI_MAX;
  logic [7:0] cnt_nxt;
  logic up_nxt, ovf_ev;
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    up_nxt = up_r;
    ovf_ev = 1'b0;
    case (mode)
      ATRI_NORMAL: ovf_ev = (cnt_r == ATRI_MAX);
      ATRI_CTC: begin
        ovf_ev = (cnt_r == ATRI_MAX);
        if (cnt_r == ocr_r[0]) cnt_nxt = ATRI_BOTTOM;
      end
      ATRI_FAST: begin
        ovf_ev = (cnt_r == top);
        if (cnt_r == top) cnt_nxt = ATRI_BOTTOM;
      end
      ATRI_PHASE: begin
        if (up_r && cnt_r == top) begin
          up_nxt = 1'b0;
          cnt_nxt = cnt_r - 8'h01;
        end else if (!up_r && cnt_r == ATRI_BOTTOM) begin
          up_nxt = 1'b1;
          ovf_ev = 1'b1;
        end else if (!up_r) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: ovf_ev = 1'b0;
    endcase
  end

  // Per channel compare and waveform
  logic [1:0] match_ev, wave_nxt;
  wire pwm = (mode == ATRI_PHASE) | (mode == ATRI_FAST);
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      wire [1:0] com = i == 0 ? ctla_r[7:6] : ctla_r[5:4];
      assign match_ev[i] = tick & (cnt_r == ocr_r[i]) & ~block_r;
      always_comb begin
        wave_nxt[i] = wave_r[i];
        if (!pwm && (match_ev[i] || force_r[i])) begin
          case (com)
            2'h1: wave_nxt[i] = ~wave_r[i];
            2'h2: wave_nxt[i] = 1'b0;
            2'h3: wave_nxt[i] = 1'b1;
            default: wave_nxt[i] = wave_r[i];
          endcase
        end else if (pwm && com[1]) begin
          if (match_ev[i]) wave_nxt[i] = (mode == ATRI_PHASE) ? (com[0] ^ ~up_r) : com[0];
          else if (mode == ATRI_FAST && tick && cnt_r == top) wave_nxt[i] = ~com[0];
        end
      end
    end
  endgenerate
  assign wave_out_a = wave_r[0];
  assign wave_out_b = wave_r[1];

  // Temporary storage, active registers and busy flags
  wire async_wr = as_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= ATRI_RST_BYTE;
      cnt_t <= ATRI_RST_BYTE;
      ocr_r <= '{ATRI_RST_BYTE, ATRI_RST_BYTE};
      ocr_t <= '{ATRI_RST_BYTE, ATRI_RST_BYTE};
      ctla_r <= ATRI_RST_BYTE;
      ctla_t <= ATRI_RST_BYTE;
      ctlb_r <= ATRI_RST_BYTE;
      ctlb_t <= ATRI_RST_BYTE;
      busy_r <= 5'h00;
      up_r <= 1'b1;
      block_r <= 1'b0;
      wave_r <= 2'h0;
      force_r <= 2'h0;
      presc_r <= '0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_s;
      presc_r <= presc_hold ? '0 : presc_r + (ATRI_PRESC_W)'(base_en);
      wave_r <= wave_nxt;
      force_r <= 2'h0;
      if (tick) begin
        cnt_r <= cnt_nxt;
        up_r <= up_nxt;
        block_r <= 1'b0;
      end
      if (wr_cnt) cnt_t <= wdata_r;
      if (wr_cmpa) ocr_t[0] <= wdata_r;
      if (wr_cmpb) ocr_t[1] <= wdata_r;
      if (wr_ctla) ctla_t <= wdata_r;
      if (wr_ctlb) ctlb_t <= wdata_r & ATRI_CTLB_RD_MASK;
      if (!async_wr) begin
        if (wr_cnt) cnt_r <= wdata_r;
        if (wr_cnt) block_r <= 1'b1;
        if (wr_cmpa) ocr_r[0] <= wdata_r;
        if (wr_cmpb) ocr_r[1] <= wdata_r;
        if (wr_ctla) ctla_r <= wdata_r;
        if (wr_ctlb) ctlb_r <= wdata_r & ATRI_CTLB_RD_MASK;
        if (wr_ctlb) force_r <= {wdata_r[6], wdata_r[7]};
      end else begin
        if (load_en) begin
          if (busy_r[ATRI_BUSY_CNT]) cnt_r <= cnt_t;
          if (busy_r[ATRI_BUSY_CNT]) block_r <= 1'b1;
          if (busy_r[ATRI_BUSY_CMPA]) ocr_r[0] <= ocr_t[0];
          if (busy_r[ATRI_BUSY_CMPB]) ocr_r[1] <= ocr_t[1];
          if (busy_r[ATRI_BUSY_CTLA]) ctla_r <= ctla_t;
          if (busy_r[ATRI_BUSY_CTLB]) ctlb_r <= ctlb_t;
        end
        // A write landing on the load edge stays busy for the next edge
        busy_r <= (load_en ? 5'h00 : busy_r) | wr_vec;
      end
    end
  end

  // Status, prescaler control, mask and flags
  wire [2:0] flag_set = {match_ev[1], match_ev[0], tick & ovf_ev};
  wire [2:0] flag_clr = (wr_flags ? wdata_r[2:0] : 3'h0) | irq_ack;
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_clock_in_enable_r <= 1'b0;
      as_r <= 1'b0;
      tsm_r <= 1'b0;
      async_prescaler_reset_r <= 1'b0;
      shared_prescaler_reset_r <= 1'b0;
      mask_r <= 3'h0;
      flags_r <= 3'h0;
    end else begin
      if (wr_stat) ext_clock_in_enable_r <= wdata_r[ATRI_BIT_EXT_CLOCK_IN_ENABLE];
      if (wr_stat) as_r <= wdata_r[ATRI_BIT_ASYNC];
      if (wr_mask) mask_r <= wdata_r[2:0];
      flags_r <= (flags_r & ~flag_clr) | flag_set;
      if (wr_gtc) begin
        tsm_r <= wdata_r[ATRI_BIT_TSM];
        async_prescaler_reset_r <= wdata_r[ATRI_BIT_ASYNC_PRESCALER_RESET] & wdata_r[ATRI_BIT_TSM] |
                    wdata_r[ATRI_BIT_ASYNC_PRESCALER_RESET] & as_r;
        shared_prescaler_reset_r <= wdata_r[ATRI_BIT_SHARED_PRESCALER_RESET] & wdata_r[ATRI_BIT_TSM];
        if (wdata_r[ATRI_BIT_SHARED_PRESCALER_RESET] && !wdata_r[ATRI_BIT_TSM]) shared_prescaler_reset_r <= 1'b1;
      end else if (!tsm_r) begin
        shared_prescaler_reset_r <= 1'b0;
        if (!as_r || osc_edge) async_prescaler_reset_r <= 1'b0;
      end
    end
  end
  assign irq_req = mask_r & flags_r & {3{cpu_global_irq_en}};

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_block;
    block_r && tick |-> !match_ev[0] && !match_ev[1];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");
  property p_match;
    tick && !block_r && cnt_r == ocr_r[0] |=> flags_r[ATRI_FLAG_CMPA];
  endproperty
  a_match: assert property (p_match) else $error("compare A flag missing");
  property p_ext;
    ext_clock_in_enable == (ext_clock_in_enable_r && as_r) && !(osc_run && ext_clock_in_enable_r);
  endproperty
  a_ext: assert property (p_ext) else $error("oscillator pin control wrong");
  property p_busy;
    as_r && wr_cnt && !load_en |=> busy_r[ATRI_BUSY_CNT] ##0 axi_rsp.bvalid;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag not set by async write");
  property p_rd_cmp;
    ar_fire && rd_idx == ATRI_IDX_CMP_A |=> axi_rsp.rdata[7:0] == $past(ocr_t[0]);
  endproperty
  a_rd_cmp: assert property (p_rd_cmp) else $error("compare read not from storage");
  property p_irq;
    irq_req[ATRI_FLAG_OVF] |-> mask_r[ATRI_FLAG_OVF] && cpu_global_irq_en && flags_r[0];
  endproperty
  a_irq: assert property (p_irq) else $error("request without enable");
  property p_w1c;
    wr_flags && wdata_r[ATRI_FLAG_CMPB] && !match_ev[1] |=> !flags_r[ATRI_FLAG_CMPB];
  endproperty
  a_w1c: assert property (p_w1c) else $error("compare B flag not cleared");
  property p_rev;
    tick && mode == ATRI_PHASE && !up_r && cnt_r == ATRI_BOTTOM |=> flags_r[ATRI_FLAG_OVF];
  endproperty
  a_rev: assert property (p_rev) else $error("overflow flag missing at reversal");
  property p_tsm_hold;
    tsm_r && !wr_gtc |=> $stable(async_prescaler_reset_r) && $stable(shared_prescaler_reset_r);
  endproperty
  a_tsm_hold: assert property (p_tsm_hold) else $error("reset bits moved in sync mode");
  property p_sync_clr;
    shared_prescaler_reset_r && !tsm_r && !wr_gtc |=> !shared_prescaler_reset_r;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("shared reset not cleared");

  c_async_load: cover property (busy_r[ATRI_BUSY_CMPA] ##1 !busy_r[ATRI_BUSY_CMPA]);
  c_ovf: cover property (flag_set[ATRI_FLAG_OVF]);
  c_wave: cover property ($rose(wave_r[0]));
  c_irq: cover property (irq_req != 3'h0);
endmodule : atri_timer
`default_nettype wire

// File: sim/test_async_timer_register_interface.sv
// Self-checking bench for the asynchronous timer register block.
// Assumes atri_pkg compiled first; bench drives every port of atri_timer itself.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_async_timer_register_interface
  import atri_pkg::*;
;
  logic clk;
  logic srst;
  atri_axi_req_s axi_req;
  atri_axi_rsp_s axi_rsp;
  logic timer_osc_in_pin;
  logic ext_clock_in_enable;
  logic osc_run;
  logic cpu_global_irq_en;
  logic [2:0] irq_ack;
  logic [2:0] irq_req;
  logic shared_prescaler_reset;
  logic wave_out_a;
  logic wave_out_b;
  int fails;
  int checks;
  logic [7:0] rst_idx [6] = '{ATRI_IDX_SYNC_PRESC, ATRI_IDX_ASYNC_STAT, ATRI_IDX_IRQ_MASK,
                             ATRI_IDX_IRQ_FLAGS, ATRI_IDX_CTRL_A, ATRI_IDX_CTRL_B};
  logic [7:0] src_val [4] = '{8'h40, 8'h60, 8'h00, 8'h20};
  logic src_ext [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic src_osc [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] busy_idx [5] = '{ATRI_IDX_COUNT, ATRI_IDX_CMP_A, ATRI_IDX_CMP_B,
                              ATRI_IDX_CTRL_A, ATRI_IDX_CTRL_B};

  atri_timer dut (
    .clk(clk),
    .srst(srst),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .timer_osc_in_pin(timer_osc_in_pin),
    .ext_clock_in_enable(ext_clock_in_enable),
    .osc_run(osc_run),
    .cpu_global_irq_en(cpu_global_irq_en),
    .irq_ack(irq_ack),
    .irq_req(irq_req),
    .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b),
    .shared_prescaler_reset(shared_prescaler_reset)
  );

  always #10 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic timeout;
    fails++;
    $display("unexpected at %0t: handshake wait ran out", $time);
    print_verdict();
  endtask : timeout

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // Address and data channels run independently; response taken once both are accepted; bready held from the start
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] er);
    int n;
    logic aw_p;
    logic w_p;
    logic b_p;
    @(posedge clk);
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    n = 0;
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= {2'h0, idx, 2'h0};
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= {24'h0, val};
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    while (b_p && n < 100) begin
      @(posedge clk);
      n++;
      if (b_p && !aw_p && !w_p && axi_rsp.bvalid === 1'b1) begin
        b_p = 1'b0;
        axi_req.bready <= 1'b0;
        `CHK(axi_rsp.bresp, er);
      end
      if (aw_p && axi_rsp.awready === 1'b1) begin
        aw_p = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w_p && axi_rsp.wready === 1'b1) begin
        w_p = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    if (b_p) timeout();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, input logic [7:0] ev, input logic [1:0] er);
    int n;
    logic ar_p;
    logic r_p;
    @(posedge clk);
    ar_p = 1'b1;
    r_p = 1'b1;
    n = 0;
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= {2'h0, idx, 2'h0};
    axi_req.rready <= 1'b1;
    while (r_p && n < 100) begin
      @(posedge clk);
      n++;
      if (!ar_p && axi_rsp.rvalid === 1'b1) begin
        r_p = 1'b0;
        axi_req.rready <= 1'b0;
        `CHK(axi_rsp.rdata, {24'h0, ev});
        `CHK(axi_rsp.rresp, er);
      end
      if (ar_p && axi_rsp.arready === 1'b1) begin
        ar_p = 1'b0;
        axi_req.arvalid <= 1'b0;
      end
    end
    if (r_p) timeout();
  endtask : axi_read

  // Synchroniser needs a few clocks per pin level
  task automatic osc_pulse;
    timer_osc_in_pin <= 1'b1;
    ticks(6);
    timer_osc_in_pin <= 1'b0;
    ticks(6);
  endtask : osc_pulse

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    axi_req = '0;
    timer_osc_in_pin = 1'b0;
    cpu_global_irq_en = 1'b0;
    irq_ack = 3'h0;
    fails = 0;
    checks = 0;
    ticks(4);
    srst <= 1'b0;
    foreach (rst_idx[i]) axi_read(rst_idx[i], ATRI_RST_BYTE, ATRI_RESP_OKAY);
    axi_read(8'h00, 8'h00, ATRI_RESP_SLVERR);
    axi_write(8'h01, 8'h55, ATRI_RESP_SLVERR);
    // Free run at full rate for one wrap plus margin
    axi_write(ATRI_IDX_CMP_A, 8'h10, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_CMP_B, 8'h20, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_COUNT, 8'h00, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_CTRL_B, 8'h01, ATRI_RESP_OKAY);
    ticks(300);
    axi_write(ATRI_IDX_CTRL_B, 8'h00, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_IRQ_FLAGS, 8'h07, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_CMP_A, 8'h10, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_IRQ_MASK, 8'h07, ATRI_RESP_OKAY);
    ticks(2);
    `CHK(irq_req, 3'h0);
    cpu_global_irq_en <= 1'b1;
    ticks(2);
    `CHK(irq_req, 3'h7);
    axi_write(ATRI_IDX_IRQ_MASK, 8'h01, ATRI_RESP_OKAY);
    ticks(1);
    `CHK(irq_req, 3'h1);
    irq_ack <= 3'h1;
    ticks(1);
    irq_ack <= 3'h0;
    axi_read(ATRI_IDX_IRQ_FLAGS, 8'h06, ATRI_RESP_OKAY);
    `CHK(irq_req, 3'h0);
    axi_write(ATRI_IDX_IRQ_FLAGS, 8'h02, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_IRQ_FLAGS, 8'h04, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_IRQ_FLAGS, 8'h04, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_IRQ_FLAGS, 8'h00, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_IRQ_MASK, 8'hff, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_IRQ_MASK, 8'h07, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_IRQ_FLAGS, 8'hf8, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_IRQ_FLAGS, 8'h00, ATRI_RESP_OKAY);
    // Count equal to compare: first tick is blocked; one below still matches
    axi_write(ATRI_IDX_CMP_A, 8'h05, ATRI_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      axi_write(ATRI_IDX_COUNT, (k == 0) ? 8'h05 : 8'h04, ATRI_RESP_OKAY);
      axi_write(ATRI_IDX_CTRL_B, 8'h01, ATRI_RESP_OKAY);
      axi_write(ATRI_IDX_CTRL_B, 8'h00, ATRI_RESP_OKAY);
      axi_read(ATRI_IDX_IRQ_FLAGS, (k == 0) ? 8'h00 : 8'h02, ATRI_RESP_OKAY);
      axi_write(ATRI_IDX_IRQ_FLAGS, 8'h07, ATRI_RESP_OKAY);
    end
    axi_write(ATRI_IDX_COUNT, 8'h33, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_COUNT, 8'h33, ATRI_RESP_OKAY);
    // Forced compare toggles both pins in normal mode
    axi_write(ATRI_IDX_CTRL_A, 8'h50, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_CTRL_B, 8'hc0, ATRI_RESP_OKAY);
    ticks(1);
    `CHK(wave_out_a, 1'b1);
    `CHK(wave_out_b, 1'b1);
    axi_read(ATRI_IDX_CTRL_A, 8'h50, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_SYNC_PRESC, 8'h01, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h00, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_SYNC_PRESC, 8'h02, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h00, ATRI_RESP_OKAY);
    axi_write(ATRI_IDX_SYNC_PRESC, 8'h83, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h83, ATRI_RESP_OKAY);
    `CHK(shared_prescaler_reset, 1'b1);
    axi_write(ATRI_IDX_SYNC_PRESC, 8'h00, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h00, ATRI_RESP_OKAY);
    `CHK(shared_prescaler_reset, 1'b0);
    // External bit settled before async select is raised
    foreach (src_val[i]) begin
      axi_write(ATRI_IDX_ASYNC_STAT, src_val[i], ATRI_RESP_OKAY);
      ticks(1);
      `CHK(ext_clock_in_enable, src_ext[i]);
      `CHK(osc_run, src_osc[i]);
    end
    axi_read(ATRI_IDX_ASYNC_STAT, 8'h20, ATRI_RESP_OKAY);
    // Rewrite all five after the source change, one at a time
    foreach (busy_idx[i]) begin
      axi_write(busy_idx[i], 8'h00, ATRI_RESP_OKAY);
      axi_read(ATRI_IDX_ASYNC_STAT, 8'h20 | (8'h10 >> i), ATRI_RESP_OKAY);
      osc_pulse();
      axi_read(ATRI_IDX_ASYNC_STAT, 8'h20, ATRI_RESP_OKAY);
    end
    axi_write(ATRI_IDX_CMP_B, 8'h5a, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_CMP_B, 8'h5a, ATRI_RESP_OKAY);
    osc_pulse();
    axi_write(ATRI_IDX_SYNC_PRESC, 8'h02, ATRI_RESP_OKAY);
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h02, ATRI_RESP_OKAY);
    osc_pulse();
    axi_read(ATRI_IDX_SYNC_PRESC, 8'h00, ATRI_RESP_OKAY);
    print_verdict();
  end
endmodule : test_async_timer_register_interface
`default_nettype wire
